// File: logic/ift_params.svh
`ifndef IFT_PARAMS_SVH
`define IFT_PARAMS_SVH
// register byte offsets
`define IFT_CFG_OFS      8'h8C
`define IFT_CNT_OFS      8'h90
`define IFT_TICK_OFS     8'h9C
// field positions and reset values
`define IFT_RUN_BIT      29
`define IFT_PRELOAD_RST  16'hFFFF
`define IFT_COUNT_RST    16'hFFFF
// timing
`define IFT_CLK_NS       100
`define IFT_TICK_CLR_NS  160
`endif

// File: logic/ift_pkg.sv
`default_nettype none
package ift_pkg;
  // host register access request
  typedef struct packed {
    logic        cs;
    logic        we;
    logic        half;
    logic        a1;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } ift_req_t;
endpackage
`default_nettype wire

// File: logic/ift_tick_counter.sv
`default_nettype none
module ift_tick_counter
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // running count
  output logic [31:0]      count
);
  import ift_pkg::*;
  logic [31:0] count_reg;
  logic [31:0] count_next;

  // never gated by any power state; wraps naturally at the top
  always_comb
  begin
    count_next = count_reg + 32'h0000_0001;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      count_reg <= 32'h0000_0000;
    else
      count_reg <= count_next;
  end

  assign count = count_reg;

  // first edge after release is skipped, since $past(reset) is still high there
  tick_step_a: assert property (@(posedge clk) disable iff (reset)
    !$past(reset) |-> count_reg == $past(count_reg) + 32'h0000_0001)
    else $error("tick counter did not advance by one");
endmodule // ift_tick_counter
`default_nettype wire

// File: logic/ift_timers.sv
`include "ift_params.svh"
`default_nettype none
module ift_timers
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // host register access, same clock domain
  input  wire ift_pkg::ift_req_t req,
  input  wire logic             irq_clear,
  // read data and interrupt
  output logic [31:0]           rdata,
  output logic                  irq_flag
);
  import ift_pkg::*;

  localparam int TICK_CLR_CYC =
    (`IFT_TICK_CLR_NS + `IFT_CLK_NS - 1) / `IFT_CLK_NS; // reset settle bound

  logic        run_reg, run_next;
  logic [15:0] preload_reg, preload_next;
  logic [15:0] count_reg, count_next;
  logic        flag_reg, flag_next;
  logic [31:0] latch_reg, latch_next;
  logic        latched_reg, latched_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [31:0] tick;
  logic        wr_cfg, rd_tick;

  ift_tick_counter u_tick
  (
    .clk   (clk),
    .reset (reset),
    .count (tick)
  );

  assign wr_cfg  = req.cs && req.we && (req.addr == `IFT_CFG_OFS);
  assign rd_tick = req.cs && !req.we && (req.addr == `IFT_TICK_OFS);

  // interval timer: control, preload and down counter
  always_comb
  begin
    run_next     = run_reg;
    preload_next = preload_reg;
    count_next   = count_reg;
    flag_next    = flag_reg && !irq_clear;
    if (wr_cfg)
    begin
      run_next     = req.wdata[`IFT_RUN_BIT];
      preload_next = req.wdata[15:0];
      if (run_reg && !req.wdata[`IFT_RUN_BIT])
        preload_next = 16'hFFFF;
    end
    if (wr_cfg && req.wdata[`IFT_RUN_BIT] && !run_reg)
      count_next = req.wdata[15:0];
    else if (run_reg)
    begin
      if (count_reg == 16'h0000)
      begin
        count_next = preload_reg;
        flag_next  = 1'b1; // set wins over clear
      end
      else
        count_next = count_reg - 16'h0001;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      run_reg     <= 1'b0;
      preload_reg <= `IFT_PRELOAD_RST;
      count_reg   <= `IFT_COUNT_RST;
      flag_reg    <= 1'b0;
    end
    else
    begin
      run_reg     <= run_next;
      preload_reg <= preload_next;
      count_reg   <= count_next;
      flag_reg    <= flag_next;
    end
  end

  // read path; half reads of the tick count share one snapshot
  always_comb
  begin
    latch_next   = latch_reg;
    latched_next = latched_reg;
    rdata_next   = 32'h0000_0000;
    if (req.cs && !req.we)
    begin
      unique case (req.addr)
        `IFT_CFG_OFS:  rdata_next = {2'b00, run_reg, 13'h0000, preload_reg};
        `IFT_CNT_OFS:  rdata_next = {16'h0000, count_reg};
        `IFT_TICK_OFS:
        begin
          if (!req.half)
            rdata_next = tick; // writes never reach here
          else if (!latched_reg)
          begin
            latch_next   = tick;
            latched_next = 1'b1;
            rdata_next   = req.a1 ? {16'h0000, tick[31:16]} : {16'h0000, tick[15:0]};
          end
          else
          begin
            latched_next = 1'b0; // companion half returns the snapshot
            rdata_next   = req.a1 ? {16'h0000, latch_reg[31:16]}
                                  : {16'h0000, latch_reg[15:0]};
          end
        end
        default:       rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      latch_reg   <= 32'h0000_0000;
      latched_reg <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
    end
    else
    begin
      latch_reg   <= latch_next;
      latched_reg <= latched_next;
      rdata_reg   <= rdata_next;
    end
  end

  assign rdata    = rdata_reg;
  assign irq_flag = flag_reg;

  sequence run_start_s;
    wr_cfg && req.wdata[`IFT_RUN_BIT] && !run_reg;
  endsequence

  start_load_a: assert property (@(posedge clk) disable iff (reset)
    run_start_s |=> run_reg && count_reg == $past(req.wdata[15:0]))
    else $error("start did not load preload");
  stop_preset_a: assert property (@(posedge clk) disable iff (reset)
    wr_cfg && run_reg && !req.wdata[`IFT_RUN_BIT] |=> preload_reg == 16'hFFFF)
    else $error("stop did not preset preload");
  halt_hold_a: assert property (@(posedge clk) disable iff (reset)
    !run_reg && !(wr_cfg && req.wdata[`IFT_RUN_BIT]) |=> $stable(count_reg))
    else $error("halted timer moved");
  down_count_a: assert property (@(posedge clk) disable iff (reset)
    run_reg && !wr_cfg && count_reg != 16'h0000 |=> count_reg == $past(count_reg) - 16'h0001)
    else $error("timer did not count down");
  zero_flag_a: assert property (@(posedge clk) disable iff (reset)
    run_reg && !wr_cfg && count_reg == 16'h0000
      |=> irq_flag && count_reg == $past(preload_reg))
    else $error("terminal count missed reload or flag");
  count_read_a: assert property (@(posedge clk) disable iff (reset)
    req.cs && !req.we && req.addr == `IFT_CNT_OFS |=> rdata == {16'h0000, $past(count_reg)})
    else $error("count read not live value");
  half_pair_a: assert property (@(posedge clk) disable iff (reset)
    rd_tick && req.half && !latched_reg |=> latch_reg == $past(tick))
    else $error("half read did not snapshot count");
  tick_write_a: assert property (@(posedge clk) disable iff (reset)
    req.cs && req.we && req.addr == `IFT_TICK_OFS |=> tick == $past(tick) + 32'h0000_0001)
    else $error("tick write disturbed counter");
  settle_a: assert property (@(posedge clk)
    $fell(reset) |-> ##[0:TICK_CLR_CYC] tick <= 32'h0000_0002)
    else $error("tick counter not cleared after reset");

  // register state right after reset release
  reset_vals_a: assert property (@(posedge clk)
    $fell(reset) |-> count_reg == `IFT_COUNT_RST && preload_reg == `IFT_PRELOAD_RST && !irq_flag)
    else $error("timer registers not at reset values");

  // control and preload writes
  run_follow_a: assert property (@(posedge clk) disable iff (reset)
    wr_cfg |=> run_reg == $past(req.wdata[`IFT_RUN_BIT]))
    else $error("run bit did not follow write");
  preload_write_a: assert property (@(posedge clk) disable iff (reset)
    wr_cfg && !(run_reg && !req.wdata[`IFT_RUN_BIT]) |=> preload_reg == $past(req.wdata[15:0]))
    else $error("preload write lost");

  // interrupt flag is sticky until cleared; halted timer cannot set it
  flag_hold_a: assert property (@(posedge clk) disable iff (reset)
    irq_flag && !irq_clear |=> irq_flag)
    else $error("interrupt flag dropped without clear");
  flag_clear_a: assert property (@(posedge clk) disable iff (reset)
    irq_clear && !run_reg |=> !irq_flag)
    else $error("interrupt flag not cleared");

  // read data path
  idle_zero_a: assert property (@(posedge clk) disable iff (reset)
    !(req.cs && !req.we) |=> rdata == 32'h0000_0000)
    else $error("read data not zero when idle");
  cfg_read_a: assert property (@(posedge clk) disable iff (reset)
    req.cs && !req.we && req.addr == `IFT_CFG_OFS
      |=> rdata == {2'b00, $past(run_reg), 13'h0000, $past(preload_reg)})
    else $error("config read wrong");
  full_tick_a: assert property (@(posedge clk) disable iff (reset)
    rd_tick && !req.half |=> rdata == $past(tick))
    else $error("full tick read wrong");
  pair_return_a: assert property (@(posedge clk) disable iff (reset)
    rd_tick && req.half && latched_reg
      |=> rdata[15:0] == ($past(req.a1) ? $past(latch_reg[31:16]) : $past(latch_reg[15:0])))
    else $error("companion half read not from snapshot");
  unmapped_read_a: assert property (@(posedge clk) disable iff (reset)
    req.cs && !req.we && req.addr != `IFT_CFG_OFS && req.addr != `IFT_CNT_OFS
      && req.addr != `IFT_TICK_OFS |=> rdata == 32'h0000_0000)
    else $error("unmapped read not zero");
endmodule // ift_timers
`default_nettype wire

// File: test/ift_host_model.sv
`default_nettype none
// host side of the register bus: one strobe per cycle, launched just after an edge
module ift_host_model
(
  // clock
  input  wire logic         clk,
  // bus request and flag clear
  output ift_pkg::ift_req_t req,
  output logic              irq_clear
);
  import ift_pkg::*;
  initial
  begin
    req       = '0;
    irq_clear = 1'b0;
  end
  // request held unchanged through its taking edge
  task automatic go(input ift_req_t r);
    req = r;
    @(posedge clk);
    #1;
  endtask
  // stale address and data inverted so nothing leans on them
  task automatic idle();
    req = '{1'b0, 1'b0, 1'b0, 1'b0, ~req.addr, ~req.wdata};
  endtask
  task automatic clr();
    irq_clear = 1'b1;
    go(req);
    irq_clear = 1'b0;
  endtask
endmodule // ift_host_model
`default_nettype wire

// File: test/tb_ift_timers.sv
`include "ift_params.svh"
`default_nettype none
module tb_ift_timers;
  timeunit 1ns;
  timeprecision 1ns;
  import ift_pkg::*;
  typedef struct packed {logic h; logic [31:0] v;} ift_exp_t;
  logic        clk;
  logic        reset;
  ift_req_t    req;
  logic        irq_clear;
  logic [31:0] rdata;
  logic        irq_flag;
  logic [31:0] cyc;
  logic [31:0] snap;
  logic        rd_seen;
  ift_exp_t    q[$];
  ift_exp_t    e;
  int          n_errors;
  int          num_checks;
  int unsigned pre;
  ift_host_model i_ift_host_model (.clk(clk), .req(req), .irq_clear(irq_clear));
  ift_timers i_ift_timers (.clk(clk), .reset(reset), .req(req), .irq_clear(irq_clear),
    .rdata(rdata), .irq_flag(irq_flag));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // cyc is the tick value the next taking edge will see
  always @(posedge clk)
  begin
    cyc     <= reset ? 32'h0 : cyc + 32'h1;
    rd_seen <= req.cs && !req.we;
  end
  // each answer is matched against the oldest note; half reads compare 16 bits
  always @(negedge clk)
    if (rd_seen === 1'b1)
    begin
      e = q.pop_front();
      chk("rdata", e.h ? {16'h0000, rdata[15:0]} : rdata, e.v);
    end
  task automatic chk(input string s, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", s, exp, got);
    end
  endtask
  task automatic rd(input logic [7:0] ad, input logic h, input logic a, input logic [31:0] v);
    q.push_back('{h, v});
    i_ift_host_model.go('{1'b1, 1'b0, h, a, ad, 32'h0});
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    i_ift_host_model.go('{1'b1, 1'b1, 1'b0, 1'b0, ad, d});
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // hang guard, far beyond the fewer than 80 cycles of the run
  initial
  begin
    #(1000 * `IFT_CLK_NS);
    n_errors++;
    summarize();
  end
  initial
  begin
    n_errors   = 0;
    num_checks = 0;
    reset      = 1'b1;
    void'($urandom(32'h8FF8));
    repeat (10) @(posedge clk);
    #1;
    reset = 1'b0;
    rd(`IFT_CFG_OFS, 1'b0, 1'b0, 32'h0000FFFF);
    rd(`IFT_CNT_OFS, 1'b0, 1'b0, 32'h0000FFFF);
    wr(`IFT_CFG_OFS, 32'hDFFFABCD);
    rd(`IFT_CFG_OFS, 1'b0, 1'b0, 32'h0000ABCD);
    wr(`IFT_CNT_OFS, 32'h00001234);
    wr(`IFT_TICK_OFS, 32'hA5A5A5A5);
    rd(`IFT_CNT_OFS, 1'b0, 1'b0, 32'h0000FFFF);
    rd(`IFT_TICK_OFS, 1'b0, 1'b0, cyc);
    rd(8'h00, 1'b0, 1'b0, 32'h0);
    // upper half first; the later lower half must come from the same snapshot
    snap = cyc;
    rd(`IFT_TICK_OFS, 1'b1, 1'b1, {16'h0000, snap[31:16]});
    i_ift_host_model.idle();
    repeat (5) @(posedge clk);
    #1;
    rd(`IFT_TICK_OFS, 1'b1, 1'b0, {16'h0000, snap[15:0]});
    rd(`IFT_TICK_OFS, 1'b1, 1'b0, {16'h0000, cyc[15:0]});
    // short random interval: count walks down to zero, reloads and flags
    pre = $urandom_range(9, 2);
    wr(`IFT_CFG_OFS, 32'h20000000 | pre);
    chk("irq_flag", {31'h0, irq_flag}, 32'h0);
    for (int i = 0; i <= pre + 1; i++)
      rd(`IFT_CNT_OFS, 1'b0, 1'b0, (i > pre) ? pre : pre - i);
    chk("irq_flag", {31'h0, irq_flag}, 32'h1);
    wr(`IFT_CFG_OFS, 32'h00001234);
    rd(`IFT_CFG_OFS, 1'b0, 1'b0, 32'h0000FFFF);
    i_ift_host_model.idle();
    i_ift_host_model.clr();
    // halted timer must not flag again
    repeat (30) @(posedge clk);
    #1;
    chk("irq_flag", {31'h0, irq_flag}, 32'h0);
    repeat (2) @(posedge clk);
    summarize();
  end
endmodule // tb_ift_timers
`default_nettype wire
